// *** perf_freeze_pkg.sv ***
// Constants shared by the freeze and filter block: register map,
// field positions, reset values and filter encodings.
// Assumes a 32-bit classic Wishbone register bus.
package perf_freeze_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;

    // Global register byte offsets
    localparam logic [11:0] CAP_OFS = 12'h000;
    localparam logic [11:0] OVF_OFS = 12'h004;
    localparam logic [11:0] FRZ_OFS = 12'h008;
    localparam logic [11:0] RST_OFS = 12'h00C;

    // Per-counter block: base plus index times stride
    localparam logic [11:0] CNTR_BASE = 12'h100;
    localparam int CNTR_STRIDE_LOG2 = 5;
    localparam logic [4:0] CFG_OFS = 5'h00;
    localparam logic [4:0] DATA_OFS = 5'h04;
    localparam logic [4:0] FLT_WQ_OFS = 5'h08;
    localparam logic [4:0] FLT_TC_OFS = 5'h0C;
    localparam logic [4:0] FLT_PG_OFS = 5'h10;
    localparam logic [4:0] FLT_PASID_OFS = 5'h14;

    // Filter type codes, also bit positions of the support mask
    localparam int FLT_WQ = 0;
    localparam int FLT_TC = 1;
    localparam int FLT_PG = 2;
    localparam int FLT_PASID = 5;
    localparam int FLT_TYPES = 6;

    // Page size mask bits
    localparam int PG_4K = 0;
    localparam int PG_2M = 1;
    localparam int PG_1G = 2;
    localparam int PG_W = 3;

    // PASID filter value fields and modes
    localparam int PASID_W = 20;
    localparam int PMODE_LSB = 20;
    localparam int PMODE_MSB = 21;
    localparam logic [1:0] PMODE_EXACT = 2'h0;
    localparam logic [1:0] PMODE_ANY_PASID = 2'h1;
    localparam logic [1:0] PMODE_NO_PASID = 2'h2;
    localparam logic [1:0] PMODE_ALL = 2'h3;

    // Counter config fields
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_GFRZ_BIT = 1;

    // Reset control fields
    localparam int RST_CFG_BIT = 0;
    localparam int RST_CNT_BIT = 1;

    // Capability fields
    localparam int CAP_FLT_BIT = 0;
    localparam int CAP_WRE_BIT = 1;
    localparam int CAP_NUM_LSB = 8;
    localparam int CAP_WID_LSB = 16;

    // Reset values
    localparam logic [31:0] FLT_MASK_RST = 32'hFFFFFFFF;
    localparam logic [21:0] FLT_PASID_RST = {PMODE_ALL, 20'h00000};
    localparam logic [1:0] CFG_RST = 2'h0;

endpackage

// *** perf_filter_match.sv ***
// Filter qualification for one counter's event.
// Assumes event attributes are valid in the cycle of the event.
`timescale 1ns/1ns
`default_nettype none
module perf_filter_match
    import perf_freeze_pkg::*;
#(
    parameter int NUM_WQ = 8,
    parameter int NUM_TC = 8
)
(
    input wire logic [NUM_WQ-1:0] wq_mask_i,
    input wire logic [NUM_TC-1:0] tc_mask_i,
    input wire logic [perf_freeze_pkg::PG_W-1:0] pg_mask_i,
    input wire logic [21:0] pasid_cfg_i,
    input wire logic [perf_freeze_pkg::FLT_TYPES-1:0] support_i,
    input wire logic [$clog2(NUM_WQ)-1:0] wq_i,
    input wire logic [$clog2(NUM_TC)-1:0] tc_i,
    input wire logic [perf_freeze_pkg::PG_W-1:0] pg_i,
    input wire logic has_pasid_i,
    input wire logic [perf_freeze_pkg::PASID_W-1:0] pasid_i,
    output logic match_o
);
    import perf_freeze_pkg::*;

    logic wq_ok;
    logic tc_ok;
    logic pg_ok;
    logic pasid_ok;
    logic [1:0] mode;

    assign mode = pasid_cfg_i[PMODE_MSB:PMODE_LSB];

    always_comb
    begin
        wq_ok = wq_mask_i[wq_i];
        tc_ok = tc_mask_i[tc_i];
        pg_ok = |(pg_mask_i & pg_i);
        unique case (mode)
            PMODE_EXACT:
                pasid_ok = has_pasid_i &&
                    (pasid_i == pasid_cfg_i[PASID_W-1:0]);
            PMODE_ANY_PASID: pasid_ok = has_pasid_i;
            PMODE_NO_PASID: pasid_ok = !has_pasid_i;
            PMODE_ALL: pasid_ok = 1'b1;
        endcase
    end

    assign match_o = (wq_ok || !support_i[FLT_WQ]) &&
        (tc_ok || !support_i[FLT_TC]) &&
        (pg_ok || !support_i[FLT_PG]) &&
        (pasid_ok || !support_i[FLT_PASID]);

endmodule
`default_nettype wire

// *** perf_freeze_filter.sv ***
// Bank of event counters with freeze, global freeze on overflow
// and per-counter event filters, on a classic Wishbone slave.
// Assumes events and their attributes come from logic on clk_i.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Writing one to a freeze bit stops that counter, value kept.
// - Writing zero to a freeze bit resumes counting.
// - Resumed counter continues from its held value, no reload.
// - Freeze bits read and write; read shows live freeze state.
// - Overflow with global freeze option sets every freeze bit.
// - Each counter has one filter register per filter type.
// - Capability register reports filter support.
// - Filters an event does not support do not gate it.
// - With several filters, count only if all match.
// - No validity checks on programming; no error raised.
// - Filter code 0 is a work_queue bitmask.
// - Filter code 1 is a traffic class bitmask.
// - Filter code 2 page size mask: 4K, 2M, 1G.
// - Filter code 5: bits 21:20 mode, 19:0 PASID.
// - PASID modes exact, any, none, all; all is default.
// - Overflow sets that counter's overflow_status bit, except in a cycle where a reset register write clears counts.
// - While enabled, filter writes and config writes other than the enable bit are ignored.
module perf_freeze_filter
    import perf_freeze_pkg::*;
#(
    parameter int NUM_CNTR = 4,
    parameter int CNT_W = 32,
    parameter int NUM_WQ = 8,
    parameter int NUM_TC = 8
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [perf_freeze_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [perf_freeze_pkg::DATA_W-1:0] wb_dat_i,
    output logic [perf_freeze_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_CNTR-1:0] evt_i,
    input wire logic [perf_freeze_pkg::FLT_TYPES-1:0] evt_flt_sup_i,
    input wire logic [$clog2(NUM_WQ)-1:0] evt_wq_i,
    input wire logic [$clog2(NUM_TC)-1:0] evt_tc_i,
    input wire logic [perf_freeze_pkg::PG_W-1:0] evt_pg_i,
    input wire logic evt_has_pasid_i,
    input wire logic [perf_freeze_pkg::PASID_W-1:0] evt_pasid_i,
    output logic [NUM_CNTR-1:0] freeze_o,
    output logic [NUM_CNTR-1:0] overflow_o
);
    import perf_freeze_pkg::*;

    logic ack_reg;
    logic [DATA_W-1:0] rdat_reg;
    logic [DATA_W-1:0] rdat_next;
    logic [NUM_CNTR-1:0] counter_freeze_bits_reg;
    logic [NUM_CNTR-1:0] overflow_status_reg;
    logic [1:0] counter_config_reg [NUM_CNTR];
    logic [CNT_W-1:0] count_reg [NUM_CNTR];
    logic [NUM_WQ-1:0] flt_wq_reg [NUM_CNTR];
    logic [NUM_TC-1:0] flt_tc_reg [NUM_CNTR];
    logic [PG_W-1:0] flt_pg_reg [NUM_CNTR];
    logic [21:0] flt_pasid_reg [NUM_CNTR];
    logic [NUM_CNTR-1:0] match;
    logic [NUM_CNTR-1:0] inc;
    logic [NUM_CNTR-1:0] ovf_evt;
    logic gfrz_evt;
    logic wr_acc;
    logic [DATA_W-1:0] wmask;
    logic [DATA_W-1:0] cap_val;
    logic rst_cfg;
    logic rst_cnt;

    // Merge write data under byte enables
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_v
    );
        merge = (old_v & ~wmask) | (wb_dat_i & wmask);
    endfunction

    // Counter block hit for index i and register offset
    function automatic logic hit_cntr(input int i, input logic [4:0] ofs);
        logic [11:0] base;
        base = CNTR_BASE + 12'(i << CNTR_STRIDE_LOG2);
        hit_cntr = (wb_adr_i[11:5] == base[11:5]) &&
            (wb_adr_i[4:0] == ofs);
    endfunction

    always_comb
    begin
        for (int b = 0; b < 4; b++)
        begin
            wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    end

    // Write takes effect on the edge the master sees ack
    assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
    assign rst_cfg = wr_acc && (wb_adr_i == RST_OFS) &&
        wb_sel_i[0] && wb_dat_i[RST_CFG_BIT];
    assign rst_cnt = wr_acc && (wb_adr_i == RST_OFS) &&
        wb_sel_i[0] && wb_dat_i[RST_CNT_BIT];

    always_comb
    begin
        cap_val = '0;
        cap_val[CAP_FLT_BIT] = 1'b1;
        cap_val[CAP_WRE_BIT] = 1'b0;
        cap_val[CAP_NUM_LSB +: 8] = 8'(NUM_CNTR);
        cap_val[CAP_WID_LSB +: 8] = 8'(CNT_W);
    end

    // one filter register per type per counter
    genvar g;
    generate
        for (g = 0; g < NUM_CNTR; g++)
        begin : g_flt
            perf_filter_match #(
                .NUM_WQ(NUM_WQ),
                .NUM_TC(NUM_TC)
            ) u_match (
                .wq_mask_i(flt_wq_reg[g]),
                .tc_mask_i(flt_tc_reg[g]),
                .pg_mask_i(flt_pg_reg[g]),
                .pasid_cfg_i(flt_pasid_reg[g]),
                .support_i(evt_flt_sup_i),
                .wq_i(evt_wq_i),
                .tc_i(evt_tc_i),
                .pg_i(evt_pg_i),
                .has_pasid_i(evt_has_pasid_i),
                .pasid_i(evt_pasid_i),
                .match_o(match[g])
            );
        end
    endgenerate

    always_comb
    begin
        gfrz_evt = 1'b0;
        for (int i = 0; i < NUM_CNTR; i++)
        begin
            inc[i] = evt_i[i] && match[i] &&
                counter_config_reg[i][CFG_EN_BIT] &&
                !counter_freeze_bits_reg[i];
            ovf_evt[i] = inc[i] && (&count_reg[i]);
            if (ovf_evt[i] && counter_config_reg[i][CFG_GFRZ_BIT])
            begin
                gfrz_evt = 1'b1;
            end
        end
    end

    // Bus answer: one wait state, ack for one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdat_reg <= '0;
        end
        else
        begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            rdat_reg <= rdat_next;
        end
    end

    // Unmapped addresses read zero
    always_comb
    begin
        rdat_next = '0;
        unique case (wb_adr_i)
            CAP_OFS: rdat_next = cap_val;
            OVF_OFS: rdat_next[NUM_CNTR-1:0] = overflow_status_reg;
            FRZ_OFS: rdat_next[NUM_CNTR-1:0] = counter_freeze_bits_reg;
            default:
            begin
                for (int i = 0; i < NUM_CNTR; i++)
                begin
                    if (hit_cntr(i, CFG_OFS))
                        rdat_next[1:0] = counter_config_reg[i];
                    if (hit_cntr(i, DATA_OFS))
                        rdat_next[CNT_W-1:0] = count_reg[i];
                    if (hit_cntr(i, FLT_WQ_OFS))
                        rdat_next[NUM_WQ-1:0] = flt_wq_reg[i];
                    if (hit_cntr(i, FLT_TC_OFS))
                        rdat_next[NUM_TC-1:0] = flt_tc_reg[i];
                    if (hit_cntr(i, FLT_PG_OFS))
                        rdat_next[PG_W-1:0] = flt_pg_reg[i];
                    if (hit_cntr(i, FLT_PASID_OFS))
                        rdat_next[21:0] = flt_pasid_reg[i];
                end
            end
        endcase
    end

    // Freeze bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i || rst_cfg)
        begin
            counter_freeze_bits_reg <= '0;
        end
        // hardware set wins over software write
        else if (gfrz_evt)
        begin
            counter_freeze_bits_reg <= '1;
        end
        else if (wr_acc && wb_adr_i == FRZ_OFS)
        begin
            counter_freeze_bits_reg <=
                NUM_CNTR'(merge(DATA_W'(counter_freeze_bits_reg)));
        end
    end

    // sticky overflow status, set wins over an overflow_status write clear, rst_cnt clear wins over set
    always_ff @(posedge clk_i)
    begin
        if (rst_i || rst_cnt)
        begin
            overflow_status_reg <= '0;
        end
        else if (wr_acc && wb_adr_i == OVF_OFS)
        begin
            overflow_status_reg <= (overflow_status_reg &
                ~NUM_CNTR'(wb_dat_i & wmask)) | ovf_evt;
        end
        else
        begin
            overflow_status_reg <= overflow_status_reg | ovf_evt;
        end
    end

    // Configuration and filters
    // any value is accepted, nothing checked
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NUM_CNTR; i++)
        begin
            if (rst_i || rst_cfg)
            begin
                counter_config_reg[i] <= CFG_RST;
                flt_wq_reg[i] <= NUM_WQ'(FLT_MASK_RST);
                flt_tc_reg[i] <= NUM_TC'(FLT_MASK_RST);
                flt_pg_reg[i] <= PG_W'(FLT_MASK_RST);
                // PASID mode defaults to match all
                flt_pasid_reg[i] <= FLT_PASID_RST;
            end
            else if (wr_acc && counter_config_reg[i][CFG_EN_BIT])
            begin
                if (hit_cntr(i, CFG_OFS) && wb_sel_i[0])
                    counter_config_reg[i][CFG_EN_BIT] <=
                        wb_dat_i[CFG_EN_BIT];
            end
            else if (wr_acc)
            begin
                if (hit_cntr(i, CFG_OFS))
                    counter_config_reg[i] <=
                        2'(merge(DATA_W'(counter_config_reg[i])));
                if (hit_cntr(i, FLT_WQ_OFS))
                    flt_wq_reg[i] <= NUM_WQ'(merge(DATA_W'(flt_wq_reg[i])));
                if (hit_cntr(i, FLT_TC_OFS))
                    flt_tc_reg[i] <= NUM_TC'(merge(DATA_W'(flt_tc_reg[i])));
                if (hit_cntr(i, FLT_PG_OFS))
                    flt_pg_reg[i] <= PG_W'(merge(DATA_W'(flt_pg_reg[i])));
                if (hit_cntr(i, FLT_PASID_OFS))
                    flt_pasid_reg[i] <=
                        22'(merge(DATA_W'(flt_pasid_reg[i])));
            end
        end
    end

    // Counter data; writable only while disabled
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NUM_CNTR; i++)
        begin
            if (rst_i || rst_cnt)
            begin
                count_reg[i] <= '0;
            end
            else if (wr_acc && hit_cntr(i, DATA_OFS) &&
                !counter_config_reg[i][CFG_EN_BIT])
            begin
                count_reg[i] <= CNT_W'(merge(DATA_W'(count_reg[i])));
            end
            else if (inc[i])
            begin
                count_reg[i] <= count_reg[i] + 1'b1;
            end
        end
    end

    // Status copies for the outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            freeze_o <= '0;
            overflow_o <= '0;
        end
        else
        begin
            freeze_o <= counter_freeze_bits_reg;
            overflow_o <= overflow_status_reg;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

endmodule
`default_nettype wire

// *** perf_freeze_filter_monitor.sv ***
// Checker for perf_freeze_filter: bus timing, freeze and overflow bits.
// Assumes a master that holds each request until ack.
`timescale 1ns/1ns
`default_nettype none
module perf_freeze_filter_monitor
    import perf_freeze_pkg::*;
#(
    parameter int NUM_CNTR = 4,
    parameter int CNT_W = 32
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [perf_freeze_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [perf_freeze_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [NUM_CNTR-1:0] evt_i,
    input wire logic [NUM_CNTR-1:0] freeze_o,
    input wire logic [NUM_CNTR-1:0] overflow_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic wr_frz;
    logic wr_ovf;
    logic wr_rst;
    assign wr_frz = wb_ack_o && wb_we_i && wb_adr_i == FRZ_OFS;
    assign wr_ovf = wb_ack_o && wb_we_i && wb_adr_i == OVF_OFS;
    assign wr_rst = wb_ack_o && wb_we_i && wb_adr_i == RST_OFS;
    // Outputs lag the registers one cycle, hence depth two
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    ack_cause_a: assert property
        (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    frz_clear_a: assert property
        (|(~freeze_o & $past(freeze_o)) |-> $past(wr_frz || wr_rst, 2))
        else $error("freeze bit cleared without write");
    frz_all_a: assert property
        (|(freeze_o & ~$past(freeze_o)) && !$past(wr_frz, 2)
            |-> &freeze_o && $past(|evt_i, 2))
        else $error("hardware freeze not on all counters");
    ovf_clear_a: assert property
        (|(~overflow_o & $past(overflow_o)) |-> $past(wr_ovf || wr_rst, 2))
        else $error("overflow bit lost without write");
    ovf_set_a: assert property
        ((overflow_o & ~$past(overflow_o) & ~$past(evt_i, 2)) == '0)
        else $error("overflow bit set without event");
    cap_read_a: assert property
        (wb_ack_o && !wb_we_i && wb_adr_i == CAP_OFS |-> wb_dat_o[0]
            && wb_dat_o[15:8] == NUM_CNTR && wb_dat_o[23:16] == CNT_W)
        else $error("capability word wrong");
endmodule
bind perf_freeze_filter perf_freeze_filter_monitor
    #(.NUM_CNTR(NUM_CNTR), .CNT_W(CNT_W)) mon (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
    .evt_i, .freeze_o, .overflow_o);
`default_nettype wire

// *** tb_perf_freeze_filter.sv ***
// Self-checking bench for perf_freeze_filter over classic Wishbone.
// Assumes default parameters: 4 counters of 32 bits.
`timescale 1ns/1ns
`default_nettype none
module tb_perf_freeze_filter;
    import perf_freeze_pkg::*;
    typedef struct {string nm; logic [31:0] v;} note_s;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [11:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0, evt_i = '0, freeze_o, overflow_o;
    logic [31:0] wb_dat_i = '0, wb_dat_o, seed = 32'h57CF, c0, p;
    logic wb_ack_o, evt_has_pasid_i = 0;
    logic [5:0] evt_flt_sup_i = '0;
    logic [2:0] evt_wq_i = '0, evt_tc_i = '0, evt_pg_i = 3'h1;
    logic [19:0] evt_pasid_i = '0;
    logic [17:0] r;
    int n_errors = 0, tests_run = 0, cyc_n = 0;
    note_s q[$];
    note_s e;
    // Row: support, wq, tc, page, has pasid, pasid off, counted
    logic [17:0] rows [8] = '{
        18'b100111_010_001_010_1_0_1,
        18'b100111_011_001_010_1_0_0,
        18'b100111_010_000_010_1_0_0,
        18'b100111_010_001_001_1_0_0,
        18'b100111_010_001_100_1_0_0,
        18'b100111_010_001_010_1_1_0,
        18'b000000_011_000_001_0_0_1,
        18'b000001_010_000_001_0_0_1};
    perf_freeze_filter uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .evt_i, .evt_flt_sup_i, .evt_wq_i, .evt_tc_i, .evt_pg_i,
        .evt_has_pasid_i, .evt_pasid_i, .freeze_o, .overflow_o);
    always #20 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [11:0] ca(input int i, input logic [4:0] o);
        return CNTR_BASE + 12'(i << CNTR_STRIDE_LOG2) + 12'(o);
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, x);
        tests_run++;
        if (seen !== x)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, x, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
        input string nm);
        q.push_back('{nm, x});
        bus(1'b0, a, '0);
    endtask
    // Events stay high n cycles, one count per cycle
    task automatic ev(input logic [3:0] m, input logic [5:0] sp,
        input logic [2:0] w, t, pg, input logic h, input logic [19:0] pa,
        input int n);
        @(posedge clk_i);
        evt_i <= m;
        evt_flt_sup_i <= sp;
        evt_wq_i <= w;
        evt_tc_i <= t;
        evt_pg_i <= pg;
        evt_has_pasid_i <= h;
        evt_pasid_i <= pa;
        repeat (n) @(posedge clk_i);
        evt_i <= '0;
    endtask
    // Read results are checked when ack shows, in request order
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n > 20000)
        begin
            n_errors++;
            stop_test();
        end
        else if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
        begin
            e = q.pop_front();
            chk(e.nm, wb_dat_o, e.v);
            // Pin copies were loaded on the same edge as the read data
            if (wb_adr_i == FRZ_OFS)
                chk("freeze pins", 32'(freeze_o), e.v);
            if (wb_adr_i == OVF_OFS)
                chk("overflow pins", 32'(overflow_o), e.v);
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CAP_OFS, 32'h00200401, "capability");
        rd(FRZ_OFS, '0, "freeze reset");
        rd(12'h0F0, '0, "unmapped");
        rd(ca(0, FLT_PASID_OFS), 32'h00300000, "pasid reset");
        $display("done: reset values");
        seed = lfsr(seed);
        p = {12'h000, seed[19:0]};
        c0 = lfsr(seed);
        wr(ca(0, DATA_OFS), c0);
        wr(ca(0, FLT_WQ_OFS), 32'h04);
        wr(ca(0, FLT_TC_OFS), 32'h02);
        wr(ca(0, FLT_PG_OFS), 32'h02);
        wr(ca(0, FLT_PASID_OFS), p);
        wr(ca(0, CFG_OFS), 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            r = rows[i];
            ev(4'h1, r[17:12], r[11:9], r[8:6], r[5:3], r[2],
                p[19:0] ^ 20'(r[1]), 1);
            c0 += 32'(r[0]);
            rd(ca(0, DATA_OFS), c0, "filtered count");
        end
        for (int m = 1; m < 4; m++)
        begin
            wr(ca(0, CFG_OFS), '0);
            wr(ca(0, FLT_PASID_OFS), {10'h0, 2'(m), p[19:0]});
            wr(ca(0, CFG_OFS), 32'h1);
            ev(4'h1, 6'h20, 3'h2, 3'h1, 3'h2, 1'b1, ~p[19:0], 1);
            ev(4'h1, 6'h20, 3'h2, 3'h1, 3'h2, 1'b0, p[19:0], 1);
            c0 += 32'((m != 2) + (m > 1));
            rd(ca(0, DATA_OFS), c0, "pasid mode");
        end
        wr(ca(0, FLT_WQ_OFS), '0);
        wr(ca(0, DATA_OFS), '0);
        ev(4'h1, 6'h01, 3'h2, 3'h0, 3'h1, 1'b0, '0, 1);
        c0++;
        rd(ca(0, FLT_WQ_OFS), 32'h04, "locked mask");
        rd(ca(0, DATA_OFS), c0, "locked count");
        $display("done: filters");
        wr(FRZ_OFS, 32'h1);
        ev(4'h1, 6'h00, 3'h0, 3'h0, 3'h1, 1'b0, '0, 2);
        rd(FRZ_OFS, 32'h1, "freeze set");
        rd(ca(0, DATA_OFS), c0, "frozen count");
        wr(FRZ_OFS, '0);
        ev(4'h1, 6'h00, 3'h0, 3'h0, 3'h1, 1'b0, '0, 3);
        c0 += 32'd3;
        rd(FRZ_OFS, '0, "freeze clear");
        rd(ca(0, DATA_OFS), c0, "resumed count");
        $display("done: freeze");
        wr(ca(1, DATA_OFS), 32'hFFFFFFFF);
        wr(ca(2, DATA_OFS), 32'hFFFFFFFF);
        wr(ca(2, CFG_OFS), 32'h1);
        ev(4'h4, 6'h00, 3'h0, 3'h0, 3'h1, 1'b0, '0, 1);
        rd(OVF_OFS, 32'h4, "plain overflow");
        rd(FRZ_OFS, '0, "no global freeze");
        wr(ca(1, CFG_OFS), 32'h3);
        ev(4'h2, 6'h00, 3'h0, 3'h0, 3'h1, 1'b0, '0, 1);
        ev(4'h1, 6'h00, 3'h0, 3'h0, 3'h1, 1'b0, '0, 1);
        rd(FRZ_OFS, 32'hF, "global freeze");
        rd(OVF_OFS, 32'h6, "both overflows");
        rd(ca(1, DATA_OFS), '0, "wrapped count");
        rd(ca(0, DATA_OFS), c0, "held count");
        wr(OVF_OFS, 32'h6);
        rd(OVF_OFS, '0, "overflow cleared");
        wr(RST_OFS, 32'h3);
        rd(FRZ_OFS, '0, "freeze after clear");
        rd(ca(0, DATA_OFS), '0, "count after clear");
        $display("done: overflow");
        repeat (3) @(posedge clk_i);
        stop_test();
    end
endmodule
`default_nettype wire
